// ===== design/tx_channel_unit.sv
// The AHB-Lite slave port and the address map were decided locally.
`timescale 1ns/1ps
module tx_channel_unit #(
    parameter int NCH   = tx_pkg::NUM_CH,
    parameter int DEPTH = tx_pkg::FIFO_DEPTH
) (
    input  wire logic                            hclk,
    input  wire logic                            hresetn,
    input  wire logic                            hsel,
    input  wire logic [31:0]                     haddr,
    input  wire logic [1:0]                      htrans,
    input  wire logic                            hwrite,
    input  wire logic [2:0]                      hsize,
    input  wire logic [31:0]                     hwdata,
    input  wire logic                            hready,
    output logic                                 hreadyout,
    output logic                                 hresp,
    output logic [31:0]                          hrdata,
    input  wire logic                            line_rate_clock,
    output logic [NCH-1:0]                       tx_one_line,
    output logic [NCH-1:0]                       tx_zero_line,
    output logic                                 ch3_loop_one_line,
    output logic                                 ch3_loop_zero_line,
    output logic                                 transmit_irq_request
);
    localparam int PW = $clog2(DEPTH);
    localparam int HW = tx_pkg::HALF_W;

    typedef struct packed {
        logic                                bus_wr;
        logic [tx_pkg::ADDR_W-1:0]           addr;
        logic [31:0]                         rdata;
        logic [2:0]                          sync;
        logic                                line_lvl;
        logic [HW-1:0]                       mask;
        logic                                irq;
        logic [NCH-1:0][HW-1:0]              div;
        logic [NCH-1:0][HW-1:0]              ctl;
        logic [NCH-1:0][HW-1:0]              upper;
        logic [NCH-1:0][PW-1:0]              wptr;
        logic [NCH-1:0][PW-1:0]              rptr;
        logic [NCH-1:0][tx_pkg::CNT_W-1:0]   cnt;
        logic [NCH-1:0]                      ready;
        logic [NCH-1:0]                      busy;
        logic [NCH-1:0][tx_pkg::MSG_W-1:0]   shift;
        logic [NCH-1:0][4:0]                 bitn;
        logic [NCH-1:0][4:0]                 gapn;
        logic [NCH-1:0][HW-1:0]              divn;
        tx_pkg::ch_state_e [NCH-1:0]         st;
        logic [NCH-1:0]                      one;
        logic [NCH-1:0]                      zero;
        logic                                loop_one;
        logic                                loop_zero;
    } state_s;

    state_s s;
    state_s n;

    logic [NCH-1:0]                    push;
    logic [NCH-1:0]                    pop;
    logic [NCH-1:0][tx_pkg::MSG_W-1:0] mem_rd;

    // ------------------------------------------------------------
    // Message stores, one per channel
    // ------------------------------------------------------------
    for (genvar g = 0; g < NCH; g++)
    begin : g_ch
        tx_msg_if #(.WIDTH(tx_pkg::MSG_W), .DEPTH(DEPTH)) mif ();

        assign mif.wr_en   = push[g];
        assign mif.wr_addr = s.wptr[g];
        assign mif.wr_data = {s.upper[g], hwdata[HW-1:0]};
        assign mif.rd_addr = s.rptr[g];
        assign mem_rd[g]   = mif.rd_data;

        tx_msg_mem #(.WIDTH(tx_pkg::MSG_W), .DEPTH(DEPTH)) u_mem (
            .hclk    (hclk),
            .hresetn (hresetn),
            .port    (mif.mem)
        );
    end

    // ------------------------------------------------------------
    // Bus, channel engines and status
    // ------------------------------------------------------------
    always_comb
    begin
        logic [tx_pkg::ADDR_W-1:0] a;
        logic [tx_pkg::ADDR_W-1:0] base;
        logic [31:0]               rv;
        logic [HW-1:0]             stat;
        logic [tx_pkg::CNT_W-1:0]  cause;
        logic                      cause_v;
        logic                      tick;
        logic                      en;
        logic                      wrap;
        logic [4:0]                gap;
        logic [tx_pkg::MSG_W-1:0]  msg;
        logic                      par;
        logic                      bit_on;
        a       = haddr[tx_pkg::ADDR_W-1:0];
        base    = '0;
        rv      = '0;
        stat    = '0;
        cause   = '0;
        cause_v = 1'b0;
        tick    = 1'b0;
        en      = 1'b0;
        wrap    = 1'b0;
        gap     = '0;
        msg     = '0;
        par     = 1'b0;
        bit_on  = 1'b0;
        n       = s;
        push    = '0;
        pop     = '0;

        // Status and cause priority from current state
        for (int c = 0; c < NCH; c++)
        begin
            stat[tx_pkg::STAT_EMPTY_BASE + 2 * c] = (s.cnt[c] == '0);
            stat[tx_pkg::STAT_EOT_BASE + 2 * c]   = s.busy[c];
        end
        for (int c = NCH - 1; c >= 0; c--)
        begin
            if (stat[tx_pkg::STAT_EMPTY_BASE + 2 * c] && s.mask[tx_pkg::STAT_EMPTY_BASE + 2 * c])
            begin
                cause   = tx_pkg::CAUSE_EMPTY_BASE + tx_pkg::CNT_W'(2 * c);
                cause_v = 1'b1;
            end
        end
        for (int c = NCH - 1; c >= 0; c--)
        begin
            if (stat[tx_pkg::STAT_EOT_BASE + 2 * c] && s.mask[tx_pkg::STAT_EOT_BASE + 2 * c])
            begin
                cause   = tx_pkg::CAUSE_EOT_BASE + tx_pkg::CNT_W'(2 * c);
                cause_v = 1'b1;
            end
        end
        n.irq = |(stat & s.mask);

        // Address phase: capture write, prepare read data
        n.bus_wr = 1'b0;
        if (hsel && hready && htrans[tx_pkg::HTRANS_ACTIVE])
        begin
            n.bus_wr = hwrite;
            n.addr   = a;
            if (a == tx_pkg::OFF_STATUS)
            begin
                rv = 32'(stat);
            end
            else if (a == tx_pkg::OFF_MASK)
            begin
                rv = 32'(s.mask);
            end
            else if (a == tx_pkg::OFF_CAUSE)
            begin
                rv = 32'({cause_v, cause});
            end
            for (int c = 0; c < NCH; c++)
            begin
                base = tx_pkg::ADDR_W'(c * tx_pkg::CH_STRIDE);
                if (a == base + tx_pkg::OFF_CTL)
                begin
                    rv = 32'(s.ctl[c] | HW'(s.cnt[c]));
                end
            end
            n.rdata = rv;
        end

        if (s.bus_wr && s.addr == tx_pkg::OFF_MASK)
        begin
            n.mask = hwdata[HW-1:0];
        end

        // Line clock: three stages, a change counts once stages two and three agree
        n.sync = {s.sync[1:0], line_rate_clock};
        if (s.sync[1] == s.sync[2])
        begin
            n.line_lvl = s.sync[2];
        end
        tick = n.line_lvl && !s.line_lvl;

        for (int c = 0; c < NCH; c++)
        begin
            base = tx_pkg::ADDR_W'(c * tx_pkg::CH_STRIDE);
            if (s.bus_wr && s.addr == base + tx_pkg::OFF_DIV)
            begin
                n.div[c] = hwdata[HW-1:0];
            end
            if (s.bus_wr && s.addr == base + tx_pkg::OFF_CTL)
            begin
                n.ctl[c] = hwdata[HW-1:0] & tx_pkg::CTL_WMASK;
                if (c != tx_pkg::TEST_CH)
                begin
                    n.ctl[c][tx_pkg::CTL_TEST] = 1'b0;
                end
            end
            if (s.bus_wr && s.addr == base + tx_pkg::OFF_UPPER)
            begin
                n.upper[c] = hwdata[HW-1:0];
            end
            push[c] = s.bus_wr && s.addr == base + tx_pkg::OFF_LOWER
                      && s.ctl[c][tx_pkg::CTL_FCLR]
                      && s.cnt[c] != tx_pkg::COUNT_FULL;

            // Serial engine
            en   = s.ctl[c][tx_pkg::CTL_EN];
            gap  = s.ctl[c][tx_pkg::CTL_GAP_HI:tx_pkg::CTL_GAP_LO];
            wrap = tick && (s.divn[c] == s.div[c] - HW'(1));
            msg  = mem_rd[c];
            par  = ^msg[tx_pkg::MSG_W-2:0];
            if (s.ctl[c][tx_pkg::CTL_PEN])
            begin
                msg[tx_pkg::MSG_W-1] = s.ctl[c][tx_pkg::CTL_PODD] ? ~par : par;
            end
            if (tick && s.st[c] != tx_pkg::ST_IDLE && !wrap)
            begin
                n.divn[c] = s.divn[c] + HW'(1);
            end
            case (s.st[c])
                tx_pkg::ST_IDLE:
                begin
                    if (en && tick && s.ready[c]
                        && s.ctl[c][tx_pkg::CTL_FCLR])
                    begin
                        n.shift[c] = msg;
                        n.st[c]    = tx_pkg::ST_SEND;
                        n.divn[c]  = '0;
                        n.bitn[c]  = '0;
                        n.gapn[c]  = '0;
                        n.busy[c]  = 1'b1;
                        pop[c]     = 1'b1;
                    end
                end
                tx_pkg::ST_SEND:
                begin
                    if (wrap)
                    begin
                        n.divn[c] = '0;
                        if (s.bitn[c] == tx_pkg::LAST_BIT)
                        begin
                            n.gapn[c] = '0;
                            n.st[c]   = (gap == '0) ? tx_pkg::ST_IDLE : tx_pkg::ST_GAP;
                        end
                        else
                        begin
                            n.bitn[c]  = s.bitn[c] + 5'(1);
                            n.shift[c] = s.shift[c] >> 1;
                        end
                    end
                end
                tx_pkg::ST_GAP:
                begin
                    if (wrap)
                    begin
                        n.divn[c] = '0;
                        if (s.gapn[c] + 5'(1) == gap)
                        begin
                            n.st[c] = tx_pkg::ST_IDLE;
                        end
                        else
                        begin
                            n.gapn[c] = s.gapn[c] + 5'(1);
                        end
                    end
                end
                default:
                begin
                    n.st[c] = tx_pkg::ST_IDLE;
                end
            endcase
            if (!en)
            begin
                n.st[c] = tx_pkg::ST_IDLE;
                pop[c]  = 1'b0;
                n.shift[c] = '0;
                n.bitn[c]  = '0;
                n.gapn[c]  = '0;
                n.divn[c]  = '0;
            end

            // Queue bookkeeping
            n.cnt[c]  = s.cnt[c] + tx_pkg::CNT_W'(push[c]) - tx_pkg::CNT_W'(pop[c]);
            n.wptr[c] = s.wptr[c] + PW'(push[c]);
            n.rptr[c] = s.rptr[c] + PW'(pop[c]);
            n.ready[c] = (n.cnt[c] != '0) && (s.cnt[c] != '0) && !pop[c];
            if (!s.ctl[c][tx_pkg::CTL_FCLR])
            begin
                n.cnt[c]   = '0;
                n.wptr[c]  = '0;
                n.rptr[c]  = '0;
                n.ready[c] = 1'b0;
            end
            if (!en || (n.st[c] == tx_pkg::ST_IDLE && n.cnt[c] == '0))
            begin
                n.busy[c] = 1'b0;
            end

            // Return-to-zero outputs
            bit_on = (n.st[c] == tx_pkg::ST_SEND) && (n.divn[c] < (n.div[c] >> 1));
            n.one[c]  = bit_on && n.shift[c][0];
            n.zero[c] = bit_on && !n.shift[c][0];
            if (c == tx_pkg::TEST_CH)
            begin
                n.loop_one  = n.ctl[c][tx_pkg::CTL_TEST] && n.one[c];
                n.loop_zero = n.ctl[c][tx_pkg::CTL_TEST] && n.zero[c];
                if (n.ctl[c][tx_pkg::CTL_TEST])
                begin
                    n.one[c]  = 1'b0;
                    n.zero[c] = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s <= '0;
        end
        else
        begin
            s <= n;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign hreadyout            = 1'b1;
    assign hresp                = 1'b0;
    assign hrdata               = s.rdata;
    assign tx_one_line          = s.one;
    assign tx_zero_line         = s.zero;
    assign ch3_loop_one_line    = s.loop_one;
    assign ch3_loop_zero_line   = s.loop_zero;
    assign transmit_irq_request = s.irq;

endmodule : tx_channel_unit

// ===== design/tx_msg_if.sv
`timescale 1ns/1ps
interface tx_msg_if #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
);
    localparam int PW = $clog2(DEPTH);
    logic             wr_en;
    logic [PW-1:0]    wr_addr;
    logic [WIDTH-1:0] wr_data;
    logic [PW-1:0]    rd_addr;
    logic [WIDTH-1:0] rd_data;

    modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
    modport user (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
endinterface : tx_msg_if

// ===== design/tx_msg_mem.sv
`timescale 1ns/1ps
module tx_msg_mem #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input  wire logic hclk,
    input  wire logic hresetn,
    tx_msg_if.mem     port
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] cells;
        logic [WIDTH-1:0]            rd;
    } mem_s;

    mem_s s;
    mem_s n;

    // ------------------------------------------------------------
    // Message storage with registered read
    // ------------------------------------------------------------
    always_comb
    begin
        n = s;
        if (port.wr_en)
        begin
            n.cells[port.wr_addr] = port.wr_data;
        end
        n.rd = s.cells[port.rd_addr];
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s <= '0;
        end
        else
        begin
            s <= n;
        end
    end

    assign port.rd_data = s.rd;

endmodule : tx_msg_mem

// ===== design/tx_pkg.sv
// Function
// - Three independent transmit channels, each queuing up to eight 32-bit messages.
// - Each channel drives separate return-to-zero one and zero lines.
// - Channel three test bit 14 feeds internal loop lines, pins held low.
// - Bit rate is line clock divided by divider; it steps the shifter.
// - Parity bit 10 forces bit 31 odd or even per bit 11.
// - Idle gap between messages equals control bits 9 to 5 in bit times.
// - Count rises on lower half write, falls on load to shifter.
// - Bit 4 at zero clears queue until written one; shifting message completes.
// - Bit 15 enables; clearing it stops and discards the shifting message.
// - Empty queue sets status flag and, if unmasked, raises transmit interrupt.
// - Control bits 3 to 0 read back the queued message count.
// - Writes while eight messages are queued are dropped.
// - Status bits 15,13,11 empty and 14,12,10 end of transmission, channels 3,2,1.
// - Asynchronous active-low reset clears all registers to zero.
// - End of transmission outranks empty; channel 1 outranks 2, 2 outranks 3.
package tx_pkg;

    localparam int NUM_CH     = 3;
    localparam int FIFO_DEPTH = 8;
    localparam int MSG_W      = 32;
    localparam int HALF_W     = 16;
    localparam int CNT_W      = 4;
    localparam int ADDR_W     = 8;
    localparam int TEST_CH    = 2;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] CH_STRIDE  = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_DIV    = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CTL    = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_UPPER  = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_LOWER  = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h30;
    localparam logic [ADDR_W-1:0] OFF_MASK   = 8'h34;
    localparam logic [ADDR_W-1:0] OFF_CAUSE  = 8'h38;

    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    localparam int CTL_EN     = 15;
    localparam int CTL_TEST   = 14;
    localparam int CTL_PODD   = 11;
    localparam int CTL_PEN    = 10;
    localparam int CTL_GAP_HI = 9;
    localparam int CTL_GAP_LO = 5;
    localparam int CTL_FCLR   = 4;
    localparam logic [HALF_W-1:0] CTL_WMASK = 16'hcff0;

    // ------------------------------------------------------------
    // Status and cause
    // ------------------------------------------------------------
    localparam int STAT_EOT_BASE   = 10;
    localparam int STAT_EMPTY_BASE = 11;
    localparam logic [CNT_W-1:0] CAUSE_EOT_BASE   = 4'ha;
    localparam logic [CNT_W-1:0] CAUSE_EMPTY_BASE = 4'hb;
    localparam logic [CNT_W-1:0] COUNT_FULL       = 4'h8;

    localparam int HTRANS_ACTIVE = 1;
    localparam logic [4:0] LAST_BIT = 5'h1f;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SEND = 2'b01,
        ST_GAP  = 2'b10
    } ch_state_e;

endpackage : tx_pkg

// ===== tb/line_rx_model.sv
`timescale 1ns/1ps
module line_rx_model (
    input wire logic  hclk,
    input wire logic  hresetn,
    input wire logic  one_line,
    input wire logic  zero_line,
    output logic [31:0] word,
    output int        frames,
    output int        span
);
    logic [31:0] sh;
    logic        busy_q;
    int          nbit;
    int          idle;
    // ------------------------------------------------------------
    // Pulse decode, first bit is message bit 0
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            {sh, word, busy_q} <= '0;
            {nbit, idle, frames, span} <= '0;
        end
        else
        begin
            busy_q <= one_line | zero_line;
            if ((one_line | zero_line) && !busy_q)
            begin
                if (nbit == 0)
                    span <= idle;
                sh   <= {one_line, sh[31:1]};
                idle <= 0;
                nbit <= (nbit == 31) ? 0 : nbit + 1;
                if (nbit == 31)
                begin
                    word   <= {one_line, sh[31:1]};
                    frames <= frames + 1;
                end
            end
            else
            begin
                idle <= idle + 1;
                if (idle > 100)
                    nbit <= 0;
            end
        end
    end
endmodule : line_rx_model

// ===== tb/tx_channel_unit_bench.sv
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin num_errors++; \
    $display("unexpected at %0t: got %0h want %0h", $time, (a), (e)); end end
module tx_channel_unit_bench;
    logic        hclk = 1'b0;
    logic        lclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic [31:0] rdata;
    logic [2:0]  tx_one_line;
    logic [2:0]  tx_zero_line;
    logic        loop_one;
    logic        loop_zero;
    logic        irq;
    logic [31:0] rx1_word;
    logic [31:0] rx3_word;
    int          rx1_frames;
    int          rx3_frames;
    int          rx1_span;
    int          rx3_span;
    int          num_errors = 0;
    int          tests_run = 0;
    logic [15:0] ctl_t [3] = '{16'h8030, 16'h8c30, 16'h8430};
    logic [31:0] msg_t [3] = '{32'h80000003, 32'h00000003, 32'h80000003};
    logic [31:0] exp_t [3] = '{32'h80000003, 32'h80000003, 32'h00000003};
    always #5 hclk = ~hclk;
    always #41 lclk = ~lclk;
    tx_channel_unit DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .line_rate_clock(lclk),
        .tx_one_line(tx_one_line), .tx_zero_line(tx_zero_line), .ch3_loop_one_line(loop_one),
        .ch3_loop_zero_line(loop_zero), .transmit_irq_request(irq));
    line_rx_model u_rx1 (.hclk(hclk), .hresetn(hresetn), .one_line(tx_one_line[0]),
        .zero_line(tx_zero_line[0]), .word(rx1_word), .frames(rx1_frames), .span(rx1_span));
    line_rx_model u_rx3 (.hclk(hclk), .hresetn(hresetn), .one_line(loop_one),
        .zero_line(loop_zero), .word(rx3_word), .frames(rx3_frames), .span(rx3_span));
    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    task automatic results();
        if (num_errors == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : results
    task automatic wait_rdy();
        int n;
        for (n = 0; n < 50; n++)
        begin
            @(posedge hclk);
            if (hreadyout === 1'b1)
                break;
        end
        if (n == 50)
        begin
            num_errors++;
            results();
        end
    endtask : wait_rdy
    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= {16'h0, d};
        wait_rdy();
        rdata = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 16'h0);
    endtask : rd
    task automatic push(input logic [7:0] b, input logic [31:0] m);
        wr(b + tx_pkg::OFF_UPPER, m[31:16]);
        wr(b + tx_pkg::OFF_LOWER, m[15:0]);
    endtask : push
    task automatic idle(input int n);
        repeat (n) @(posedge hclk);
    endtask : idle
    task automatic wait_fr(input logic ch3, input int n);
        int k;
        for (k = 0; k < 3000; k++)
        begin
            @(posedge hclk);
            if ((ch3 ? rx3_frames : rx1_frames) >= n)
                break;
        end
        if (k == 3000)
        begin
            num_errors++;
            results();
        end
    endtask : wait_fr
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        rd(tx_pkg::OFF_STATUS);
        `CHK(rdata, 32'h0000a800)
        rd(8'h04);
        `CHK(rdata, 32'h0)
        rd(8'h3c);
        `CHK(rdata, 32'h0)
        wr(tx_pkg::OFF_MASK, 16'hfc00);
        idle(2);
        `CHK(irq, 1'b1)
        rd(tx_pkg::OFF_CAUSE);
        `CHK(rdata[4:0], 5'h1b)
        wr(8'h14, 16'h0010);
        for (int i = 0; i < 9; i++)
        begin
            push(8'h10, 32'h11110000 + i);
            rd(8'h14);
            `CHK(rdata[3:0], (i < 8) ? 4'(i + 1) : 4'h8)
        end
        rd(tx_pkg::OFF_STATUS);
        `CHK(rdata[13], 1'b0)
        wr(8'h14, 16'h0000);
        rd(8'h14);
        `CHK(rdata[3:0], 4'h0)
        wr(8'h00, 16'h0002);
        rd(8'h00);
        `CHK(rdata, 32'h0)
        for (int i = 0; i < 3; i++)
        begin
            wr(8'h04, 16'h0010);
            wr(8'h04, ctl_t[i]);
            push(8'h00, msg_t[i]);
            if (i == 0)
            begin
                idle(100);
                rd(tx_pkg::OFF_STATUS);
                `CHK(rdata[11:10], 2'b11)
                rd(tx_pkg::OFF_CAUSE);
                `CHK(rdata[4:0], 5'h1a)
            end
            wait_fr(1'b0, i + 1);
            `CHK(rx1_word, exp_t[i])
        end
        idle(100);
        rd(tx_pkg::OFF_STATUS);
        `CHK(rdata[10], 1'b0)
        wr(8'h04, 16'h0010);
        wr(8'h04, 16'h8070);
        push(8'h00, 32'h12345678);
        push(8'h00, 32'h0f0f0f0f);
        wait_fr(1'b0, 5);
        `CHK(rx1_span >= 62 && rx1_span <= 78, 1'b1)
        `CHK(rx1_word, 32'h0f0f0f0f)
        wr(8'h04, 16'h0010);
        wr(8'h04, 16'h8030);
        push(8'h00, 32'ha5a55a5a);
        push(8'h00, 32'h00000001);
        idle(100);
        wr(8'h04, 16'h8020);
        wait_fr(1'b0, 6);
        `CHK(rx1_word, 32'ha5a55a5a)
        rd(8'h04);
        `CHK(rdata[3:0], 4'h0)
        idle(1000);
        `CHK(rx1_frames, 6)
        wr(8'h04, 16'h0010);
        wr(8'h04, 16'h8030);
        push(8'h00, 32'h0000ffff);
        idle(100);
        wr(8'h04, 16'h0030);
        idle(1000);
        `CHK(rx1_frames, 6)
        `CHK(tx_one_line[0] | tx_zero_line[0], 1'b0)
        wr(8'h20, 16'h0002);
        wr(8'h24, 16'h0010);
        wr(8'h24, 16'hc030);
        push(8'h20, 32'h000000c3);
        wait_fr(1'b1, 1);
        `CHK(rx3_word, 32'h000000c3)
        results();
    end
endmodule : tx_channel_unit_bench
bind tx_channel_unit tx_channel_unit_checker #(.NCH(NCH)) u_chk (.hclk, .hresetn,
    .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata,
    .tx_one_line, .tx_zero_line, .ch3_loop_one_line, .ch3_loop_zero_line,
    .transmit_irq_request);

// ===== tb/tx_channel_unit_checker.sv
`timescale 1ns/1ps
module tx_channel_unit_checker #(
    parameter int NCH = 3
) (
    input wire logic           hclk,
    input wire logic           hresetn,
    input wire logic           hsel,
    input wire logic [31:0]    haddr,
    input wire logic [1:0]     htrans,
    input wire logic           hwrite,
    input wire logic           hready,
    input wire logic           hreadyout,
    input wire logic           hresp,
    input wire logic [31:0]    hrdata,
    input wire logic [NCH-1:0] tx_one_line,
    input wire logic [NCH-1:0] tx_zero_line,
    input wire logic           ch3_loop_one_line,
    input wire logic           ch3_loop_zero_line,
    input wire logic           transmit_irq_request
);
    // ------------------------------------------------------------
    // Address phase decode
    // ------------------------------------------------------------
    logic       take;
    logic       rd_take;
    logic [7:0] ra;
    assign take    = hsel && hready && htrans[1];
    assign rd_take = take && !hwrite;
    assign ra      = haddr[7:0];
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_bus_ok; hreadyout && !hresp; endproperty
    property p_rz_excl;
        (tx_one_line & tx_zero_line) == '0 && !(ch3_loop_one_line && ch3_loop_zero_line);
    endproperty
    property p_loop_pins;
        (ch3_loop_one_line || ch3_loop_zero_line)
            |-> !tx_one_line[tx_pkg::TEST_CH] && !tx_zero_line[tx_pkg::TEST_CH];
    endproperty
    property p_reset_clear;
        $rose(hresetn) |-> !tx_one_line && !tx_zero_line && !transmit_irq_request;
    endproperty
    property p_div_wo; rd_take && ra[3:0] == 4'h0 && ra < 8'h30 |=> hrdata == 32'h0; endproperty
    property p_unmapped; rd_take && ra >= 8'h3c |=> hrdata == 32'h0; endproperty
    property p_ctl_read;
        rd_take && ra[3:0] == 4'h4 && ra < 8'h30
            |=> hrdata[3:0] <= tx_pkg::COUNT_FULL && hrdata[31:16] == 16'h0;
    endproperty
    property p_status_read;
        rd_take && ra == tx_pkg::OFF_STATUS |=> (hrdata & 32'hffff03ff) == 32'h0;
    endproperty
    property p_cause;
        rd_take && ra == tx_pkg::OFF_CAUSE |=> !hrdata[4] || hrdata[3:0] >= tx_pkg::CAUSE_EOT_BASE;
    endproperty
    property p_hold; !take |=> $stable(hrdata); endproperty
    a_bus_ok: assert property (p_bus_ok) else $error("bus answer not okay");
    a_rz_excl: assert property (p_rz_excl) else $error("both lines high");
    a_loop_pins: assert property (p_loop_pins) else $error("ch3 pins driven in test");
    a_reset_clear: assert property (p_reset_clear) else $error("outputs not clear");
    a_div_wo: assert property (p_div_wo) else $error("divider read not zero");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_ctl_read: assert property (p_ctl_read) else $error("count above eight");
    a_status_read: assert property (p_status_read) else $error("status spare bits");
    a_cause: assert property (p_cause) else $error("bad cause code");
    a_hold: assert property (p_hold) else $error("read data moved");
    c_frame: cover property ($rose(tx_one_line[0]));
    c_loop: cover property ($rose(ch3_loop_one_line));
    c_irq: cover property ($rose(transmit_irq_request));
endmodule : tx_channel_unit_checker
